// ---- rtl/pfb_core.sv ----
// PWM fault, current-limit blanking and output chopping logic with an APB register slave.
// Notes on behaviour
// R1 - Five-bit code picks fault pin one to eight, comparator one to five, or fault 32.
// R2 - Fault polarity bit set means the selected fault source is active low.
// R3 - Fault mode 11 ignores the fault input; 10 is reserved.
// R4 - Fault mode 01 forces fault levels only while the fault is present.
// R5 - Fault mode 00 forces fault levels and latches the condition.
// R6 - With write lock set, fault and current-limit control writes need the unlock sequence first; the other registers are not locked.
// R7 - Software changes polarity bits only while the PWM module is disabled; the core takes such writes whatever pwm_module_enable is.
// R8 - Each enabled edge of high or low output starts the blanking counter.
// R9 - Fault edge blank enable applies leading-edge blanking to the fault input.
// R10 - Current-limit edge blank enable applies leading-edge blanking to current limit.
// R11 - Blanking duration is a twelve-bit delay; upper four bits read zero.
// R12 - Inputs are blocked by high or low output levels under own enables.
// R13 - Inputs are blocked while selected blanking signal is high or low, if enabled.
// R14 - Four-bit field selects state blank signal: none or generator one to three high.
// R15 - Four-bit field selects chop source: internal chop clock or generator high outputs.
// R16 - Chop enables gate the high and low outputs with the chop signal.
// R17 - Blanking control bits nine to six read zero and ignore writes.
// R18 - Active fault drives each output to its fault level bit.
// R19 - Active current limit with mode enabled drives outputs to current-limit levels.
// R20 - Blanking counter reloads on enabled edges and counts down to zero per clock.
// R21 - Blanking masks inputs after polarity correction, so masked reads as inactive.
//
// Local design decisions: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module pfb_core
   import pfb_pkg::*;
#(
   parameter int unsigned N_FAULT = 8,
   parameter int unsigned N_CMP = 5
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [N_FAULT-1:0] fault_pins,
   input wire logic fault32_pin,
   input wire logic [N_CMP-1:0] cmp_outs,
   input wire logic [4:0] climit_source_sel_in,
   input wire logic climit_raw_in,
   input wire logic [1:0] fault_output_levels,
   input wire logic [1:0] climit_output_levels,
   input wire logic pwm_module_enable,
   input wire logic write_lock_config,
   input wire logic gen_high_in,
   input wire logic gen_low_in,
   input wire logic generator1_high_output,
   input wire logic generator2_high_output,
   input wire logic generator3_high_output,
   input wire logic chop_clock,
   output logic high_side_output,
   output logic low_side_output,
   output logic fault_active,
   output logic climit_active
);
   ////////////////////////////////////////////////////////////////////////////////
   // Input synchronisers: external pins and comparators cross in through two flops.
   localparam int unsigned NS = N_FAULT + N_CMP + 6;
   logic [NS-1:0] sync1_q;
   logic [NS-1:0] sync2_q;
   logic [NS-1:0] raw_in;
   assign raw_in = {climit_raw_in, fault32_pin, cmp_outs, fault_pins, generator1_high_output,
                    generator2_high_output, generator3_high_output, chop_clock};
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_q <= '0;
         sync2_q <= '0;
      end else begin
         sync1_q <= raw_in;
         sync2_q <= sync1_q;
      end
   end
   logic chop_s, g3_s, g2_s, g1_s, f32_s, clraw_s;
   logic [N_FAULT-1:0] flt_s;
   logic [N_CMP-1:0] cmp_s;
   assign chop_s = sync2_q[0];
   assign g3_s = sync2_q[1];
   assign g2_s = sync2_q[2];
   assign g1_s = sync2_q[3];
   assign flt_s = sync2_q[4 +: N_FAULT];
   assign cmp_s = sync2_q[4 + N_FAULT +: N_CMP];
   assign f32_s = sync2_q[NS-2];
   assign clraw_s = sync2_q[NS-1];

   ////////////////////////////////////////////////////////////////////////////////
   // Registers.
   logic [15:0] fcl_q, lebcon_q, lebdly_q, aux_q;
   pfb_unlock_e unlock_q;
   logic [3:0] word_idx;
   logic acc, wr, rd_unmapped;
   assign acc = psel && penable;
   assign wr = acc && pwrite;
   assign word_idx = paddr[PFB_AW-1:0];
   logic hit_fcl, hit_leb, hit_dly, hit_aux, hit_unl, hit_sts, upper_zero;
   assign upper_zero = (paddr[31:5] == 27'h0000000);
   assign hit_fcl = upper_zero && !paddr[4] && word_idx == PFB_OFS_FAULT_CLIMIT_CONTROL;
   assign hit_leb = upper_zero && !paddr[4] && word_idx == PFB_OFS_EDGE_BLANKING_CONTROL;
   assign hit_dly = upper_zero && !paddr[4] && word_idx == PFB_OFS_EDGE_BLANKING_DELAY;
   assign hit_aux = upper_zero && !paddr[4] && word_idx == PFB_OFS_AUX_CHOP_BLANK_CONTROL;
   assign hit_unl = paddr == PFB_OFS_UNLOCK_BYTE;
   assign hit_sts = paddr == PFB_OFS_STATUS_BYTE;
   assign rd_unmapped = !(hit_fcl || hit_leb || hit_dly || hit_aux || hit_unl || hit_sts);

   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                           input logic [3:0] be, input logic [15:0] mask);
      logic [15:0] v;
      v = old;
      if (be[0]) v[7:0] = wd[7:0];
      if (be[1]) v[15:8] = wd[15:8];
      return v & mask;
   endfunction : merge16

   logic fcl_open, fcl_reject;
   assign fcl_open = !write_lock_config || (unlock_q == PFB_UL_OPEN);
   assign fcl_reject = wr && hit_fcl && !fcl_open;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         unlock_q <= PFB_UL_IDLE;
      end else if (wr && hit_unl) begin
         if (pwdata[15:0] == PFB_UNLOCK_KEY1) unlock_q <= PFB_UL_KEY1;
         else if (pwdata[15:0] == PFB_UNLOCK_KEY2 && unlock_q == PFB_UL_KEY1)
            unlock_q <= PFB_UL_OPEN;
         else unlock_q <= PFB_UL_IDLE;
      end else if (wr && hit_fcl) begin
         unlock_q <= PFB_UL_IDLE;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fcl_q <= PFB_FCL_RESET;
      end else if (wr && hit_fcl && fcl_open) begin // R6
         fcl_q <= merge16(fcl_q, pwdata, pstrb, PFB_FCL_MASK);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lebcon_q <= PFB_ZERO16;
         lebdly_q <= PFB_ZERO16;
         aux_q <= PFB_ZERO16;
      end else if (wr) begin
         if (hit_leb) lebcon_q <= merge16(lebcon_q, pwdata, pstrb, PFB_LEBCON_MASK); // R17
         if (hit_dly) lebdly_q <= merge16(lebdly_q, pwdata, pstrb, PFB_LEBDLY_MASK); // R11
         if (hit_aux) aux_q <= merge16(aux_q, pwdata, pstrb, PFB_AUX_MASK);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Source selection and polarity.
   function automatic logic pick_src(input logic [4:0] code, input logic [N_FAULT-1:0] f,
                                     input logic [N_CMP-1:0] c, input logic f32);
      logic r;
      r = 1'b0;
      if (code == PFB_SRC_FAULT32) r = f32;
      else if (code >= PFB_SRC_CMP_BASE && code <= PFB_SRC_CMP_LAST)
         r = c[3'(code - PFB_SRC_CMP_BASE)];
      else if (code < PFB_SRC_CMP_BASE) r = f[3'(code)];
      return r;
   endfunction : pick_src

   function automatic logic pick_gen(input logic [3:0] code, input logic dflt,
                                     input logic a, input logic b, input logic c);
      logic r;
      case (code)
         PFB_SEL_NONE: r = dflt;
         4'h1: r = a;
         4'h2: r = b;
         PFB_SEL_GEN_LAST: r = c;
         default: r = 1'b0;
      endcase
      return r;
   endfunction : pick_gen

   logic [4:0] fault_source_select;
   logic [1:0] fault_mode;
   logic fault_polarity, climit_enable, climit_polarity;
   assign fault_source_select = fcl_q[PFB_FLT_SRC_LSB +: 5];
   assign fault_mode = fcl_q[PFB_FLT_MOD_LSB +: 2];
   assign fault_polarity = fcl_q[PFB_FLT_POL_BIT];
   assign climit_enable = fcl_q[PFB_CL_MOD_BIT];
   assign climit_polarity = fcl_q[PFB_CL_POL_BIT];

   logic fault_sel, fault_corr, cl_corr;
   assign fault_sel = pick_src(fault_source_select, flt_s, cmp_s, f32_s); // R1
   assign fault_corr = fault_sel ^ fault_polarity; // R2 R7
   // The current-limit source is chosen outside this block and arrives already selected.
   assign cl_corr = clraw_s ^ climit_polarity;

   ////////////////////////////////////////////////////////////////////////////////
   // Leading-edge and state blanking.
   logic hi_prev_q, lo_prev_q;
   logic [11:0] edge_cnt_q;
   logic edge_hit;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hi_prev_q <= 1'b0;
         lo_prev_q <= 1'b0;
      end else begin
         hi_prev_q <= gen_high_in;
         lo_prev_q <= gen_low_in;
      end
   end
   assign edge_hit = (lebcon_q[PFB_HI_RISE_BIT] && gen_high_in && !hi_prev_q) ||
                     (lebcon_q[PFB_HI_FALL_BIT] && !gen_high_in && hi_prev_q) ||
                     (lebcon_q[PFB_LO_RISE_BIT] && gen_low_in && !lo_prev_q) ||
                     (lebcon_q[PFB_LO_FALL_BIT] && !gen_low_in && lo_prev_q); // R8

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         edge_cnt_q <= 12'h000;
      end else if (edge_hit) begin
         edge_cnt_q <= lebdly_q[11:0]; // R20
      end else if (edge_cnt_q != 12'h000) begin
         edge_cnt_q <= edge_cnt_q - 12'h001; // R20
      end
   end

   logic edge_blank_active, blank_sig, state_blank;
   assign edge_blank_active = edge_hit || (edge_cnt_q != 12'h000);
   assign blank_sig = pick_gen(aux_q[PFB_BLANK_SRC_LSB +: 4], 1'b0, g1_s, g2_s, g3_s); // R14
   assign state_blank =
      (lebcon_q[PFB_BLK_HI_HIGH_BIT] && gen_high_in) ||
      (lebcon_q[PFB_BLK_HI_LOW_BIT] && !gen_high_in) ||
      (lebcon_q[PFB_BLK_LO_HIGH_BIT] && gen_low_in) ||
      (lebcon_q[PFB_BLK_LO_LOW_BIT] && !gen_low_in) || // R12
      ((aux_q[PFB_BLANK_SRC_LSB +: 4] != PFB_SEL_NONE) &&
       ((lebcon_q[PFB_BLK_SIG_HIGH_BIT] && blank_sig) ||
        (lebcon_q[PFB_BLK_SIG_LOW_BIT] && !blank_sig))); // R13

   logic fault_masked, cl_masked;
   assign fault_masked = fault_corr && !state_blank &&
                         !(lebcon_q[PFB_FLTLEB_BIT] && edge_blank_active); // R9 R21
   assign cl_masked = cl_corr && !state_blank &&
                      !(lebcon_q[PFB_CLLEB_BIT] && edge_blank_active); // R10 R19 R21

   ////////////////////////////////////////////////////////////////////////////////
   // Fault latch and output override.
   logic flt_latch_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flt_latch_q <= 1'b0;
      end else if (fault_mode != PFB_FMOD_LATCH) begin
         flt_latch_q <= 1'b0;
      end else if (fault_masked || !pwm_module_enable) begin
         // The latch holds until the module is disabled or the mode is changed.
         flt_latch_q <= fault_masked; // R5
      end
   end

   logic flt_now;
   always_comb begin
      case (fault_mode)
         PFB_FMOD_LATCH: flt_now = fault_masked || flt_latch_q; // R5
         PFB_FMOD_CYCLE: flt_now = fault_masked; // R4
         PFB_FMOD_OFF: flt_now = 1'b0; // R3
         default: flt_now = 1'b0; // R3
      endcase
   end

   logic chop_sig, hi_d, lo_d, cl_now;
   assign chop_sig = pick_gen(aux_q[PFB_CHOP_SRC_LSB +: 4], chop_s, g1_s, g2_s, g3_s); // R15
   assign cl_now = climit_enable && cl_masked; // R19
   always_comb begin
      hi_d = gen_high_in && (!aux_q[PFB_CHOPH_BIT] || chop_sig); // R16
      lo_d = gen_low_in && (!aux_q[PFB_CHOPL_BIT] || chop_sig); // R16
      if (flt_now) begin
         hi_d = fault_output_levels[PFB_LVL_HI]; // R18
         lo_d = fault_output_levels[PFB_LVL_LO]; // R18
      end else if (cl_now) begin
         hi_d = climit_output_levels[PFB_LVL_HI]; // R19
         lo_d = climit_output_levels[PFB_LVL_LO]; // R19
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         high_side_output <= 1'b0;
         low_side_output <= 1'b0;
         fault_active <= 1'b0;
         climit_active <= 1'b0;
      end else begin
         high_side_output <= hi_d;
         low_side_output <= lo_d;
         fault_active <= flt_now;
         climit_active <= cl_now;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // APB answer: zero wait states, registered read data.
   logic [15:0] rd_val;
   always_comb begin
      rd_val = PFB_ZERO16;
      if (hit_fcl) rd_val = fcl_q;
      else if (hit_leb) rd_val = lebcon_q;
      else if (hit_dly) rd_val = lebdly_q;
      else if (hit_aux) rd_val = aux_q;
      else if (hit_sts) rd_val = {12'h000, unlock_q == PFB_UL_OPEN, edge_blank_active,
                                  cl_now, flt_now};
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && !penable;
         pslverr <= psel && !penable && (rd_unmapped || (pwrite && hit_fcl && !fcl_open));
         prdata <= {16'h0000, (psel && !penable && !pwrite) ? rd_val : PFB_ZERO16};
      end
   end
   logic unused_ok;
   assign unused_ok = &{1'b0, climit_source_sel_in, fcl_reject, PFB_OFS_CONFIG,
                        PFB_OFS_CONFIG_BYTE[0]};
endmodule : pfb_core
`default_nettype wire

// ---- rtl/pfb_pkg.sv ----
// Package with register map, field layouts and reset values for the PWM fault blanking block.
package pfb_pkg;
   localparam int unsigned PFB_AW = 4;
   localparam logic [3:0] PFB_OFS_FAULT_CLIMIT_CONTROL = 4'h0;
   localparam logic [3:0] PFB_OFS_EDGE_BLANKING_CONTROL = 4'h4;
   localparam logic [3:0] PFB_OFS_EDGE_BLANKING_DELAY = 4'h8;
   localparam logic [3:0] PFB_OFS_AUX_CHOP_BLANK_CONTROL = 4'hc;
   localparam logic [3:0] PFB_OFS_CONFIG = 4'h0;
   localparam logic [31:0] PFB_OFS_CONFIG_BYTE = 32'h0000_0010;
   localparam logic [31:0] PFB_OFS_UNLOCK_BYTE = 32'h0000_0014;
   localparam logic [31:0] PFB_OFS_STATUS_BYTE = 32'h0000_0018;
   localparam logic [15:0] PFB_UNLOCK_KEY1 = 16'h00aa;
   localparam logic [15:0] PFB_UNLOCK_KEY2 = 16'h0055;
   // Fault and current-limit control fields.
   localparam int unsigned PFB_FLT_MOD_LSB = 0;
   localparam int unsigned PFB_FLT_POL_BIT = 2;
   localparam int unsigned PFB_FLT_SRC_LSB = 3;
   localparam int unsigned PFB_CL_MOD_BIT = 8;
   localparam int unsigned PFB_CL_POL_BIT = 9;
   localparam int unsigned PFB_CL_SRC_LSB = 10;
   localparam logic [15:0] PFB_FCL_RESET = 16'h00f8;
   localparam logic [15:0] PFB_FCL_MASK = 16'h7fff;
   // Edge blanking control fields.
   localparam int unsigned PFB_BLK_LO_LOW_BIT = 0;
   localparam int unsigned PFB_BLK_LO_HIGH_BIT = 1;
   localparam int unsigned PFB_BLK_HI_LOW_BIT = 2;
   localparam int unsigned PFB_BLK_HI_HIGH_BIT = 3;
   localparam int unsigned PFB_BLK_SIG_LOW_BIT = 4;
   localparam int unsigned PFB_BLK_SIG_HIGH_BIT = 5;
   localparam int unsigned PFB_CLLEB_BIT = 10;
   localparam int unsigned PFB_FLTLEB_BIT = 11;
   localparam int unsigned PFB_LO_FALL_BIT = 12;
   localparam int unsigned PFB_LO_RISE_BIT = 13;
   localparam int unsigned PFB_HI_FALL_BIT = 14;
   localparam int unsigned PFB_HI_RISE_BIT = 15;
   localparam logic [15:0] PFB_LEBCON_MASK = 16'hfc3f;
   localparam logic [15:0] PFB_LEBDLY_MASK = 16'h0fff;
   // Auxiliary fields.
   localparam int unsigned PFB_CHOPL_BIT = 0;
   localparam int unsigned PFB_CHOPH_BIT = 1;
   localparam int unsigned PFB_CHOP_SRC_LSB = 2;
   localparam int unsigned PFB_BLANK_SRC_LSB = 8;
   localparam logic [15:0] PFB_AUX_MASK = 16'h0f3f;
   // Output level fields: bit 1 high side, bit 0 low side.
   localparam int unsigned PFB_LVL_HI = 1;
   localparam int unsigned PFB_LVL_LO = 0;
   localparam logic [15:0] PFB_ZERO16 = 16'h0000;
   // Fault mode codes.
   localparam logic [1:0] PFB_FMOD_LATCH = 2'h0;
   localparam logic [1:0] PFB_FMOD_CYCLE = 2'h1;
   localparam logic [1:0] PFB_FMOD_OFF = 2'h3;
   // Source codes.
   localparam logic [4:0] PFB_SRC_CMP_BASE = 5'h08;
   localparam logic [4:0] PFB_SRC_CMP_LAST = 5'h0c;
   localparam logic [4:0] PFB_SRC_FAULT32 = 5'h1f;
   localparam logic [3:0] PFB_SEL_NONE = 4'h0;
   localparam logic [3:0] PFB_SEL_GEN_LAST = 4'h3;
   typedef enum logic [1:0] {PFB_UL_IDLE, PFB_UL_KEY1, PFB_UL_OPEN} pfb_unlock_e;
endpackage : pfb_pkg

// ---- verif/pfb_core_asserts.sv ----
// Checker of bus timing, read-back gaps and output forcing for the blanking block.
`timescale 1ns/1ps
`default_nettype none
module pfb_core_chk (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [1:0] fault_output_levels,
   input wire logic [1:0] climit_output_levels,
   input wire logic high_side_output,
   input wire logic low_side_output,
   input wire logic fault_active,
   input wire logic climit_active
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   ////////////////////////////////////////////////////////////
   property p_zero_wait;
      psel && !penable |=> psel && penable && pready;
   endproperty
   a_zero_wait: assert property (p_zero_wait) else $error("no ready in access cycle");
   property p_ready_pulse;
      pready |-> psel && penable ##1 !pready;
   endproperty
   a_ready_pulse: assert property (p_ready_pulse) else $error("ready not a single pulse");
   property p_err_ready;
      pslverr |-> pready;
   endproperty
   a_err_ready: assert property (p_err_ready) else $error("error without ready");
   property p_upper_zero;
      pready |-> prdata[31:16] == 16'h0;
   endproperty
   a_upper_zero: assert property (p_upper_zero) else $error("upper read half not zero");
   property p_blank_gap;
      pready && !pwrite && paddr == 32'h4 |-> prdata[9:6] == 4'h0;
   endproperty
   a_blank_gap: assert property (p_blank_gap) else $error("blank control gap not zero");
   property p_delay_top;
      pready && !pwrite && paddr == 32'h8 |-> prdata[15:12] == 4'h0;
   endproperty
   a_delay_top: assert property (p_delay_top) else $error("delay top bits not zero");
   property p_fault_lvl;
      (fault_active && $stable(fault_output_levels)) [*2]
         |-> ({high_side_output, low_side_output} & ~fault_output_levels) == 2'h0;
   endproperty
   a_fault_lvl: assert property (p_fault_lvl) else $error("output above fault level");
   property p_climit_lvl;
      (climit_active && !fault_active && $stable(climit_output_levels)) [*2]
         |-> ({high_side_output, low_side_output} & ~climit_output_levels) == 2'h0;
   endproperty
   a_climit_lvl: assert property (p_climit_lvl) else $error("output above limit level");
   c_refused: cover property (pslverr);
   c_fault_forced: cover property (fault_active [*2]);
   c_climit_forced: cover property (climit_active && !fault_active);
endmodule : pfb_core_chk
bind pfb_core pfb_core_chk i_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .fault_output_levels(fault_output_levels),
   .climit_output_levels(climit_output_levels), .high_side_output(high_side_output),
   .low_side_output(low_side_output), .fault_active(fault_active),
   .climit_active(climit_active));
`default_nettype wire

// ---- verif/pfb_far_model.sv ----
// Behavioural model of the fault pins, comparator outputs and current-limit line.
`timescale 1ns/1ps
`default_nettype none
module pfb_far_model (
   input wire logic pclk,
   input wire logic [4:0] src,
   input wire logic act,
   input wire logic oth,
   input wire logic pol,
   input wire logic cl,
   output logic [7:0] fault_pins,
   output logic fault32_pin,
   output logic [4:0] cmp_outs,
   output logic climit_raw_in
);
   // Unselected sources sit at the level oth, so a wrong source pick shows up.
   always_ff @(posedge pclk) begin
      for (int i = 0; i < 8; i++) begin
         fault_pins[i] <= ((src == 5'(i)) ? act : oth) ^ pol;
      end
      for (int i = 0; i < 5; i++) begin
         cmp_outs[i] <= ((src == 5'(i + 8)) ? act : oth) ^ pol;
      end
      fault32_pin <= ((src == 5'h1f) ? act : oth) ^ pol;
      climit_raw_in <= cl;
   end
endmodule : pfb_far_model
`default_nettype wire

// ---- verif/pwm_fault_blanking_chop_tb_top.sv ----
// Self-checking bench: register access, fault modes, blanking and chopping.
`timescale 1ns/1ps
`default_nettype none
`define CK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fail_count++; \
   $display("wrong value %s expected %h seen %h", nm, e, g); end end
module pwm_fault_blanking_chop_tb_top;
   localparam int D = 5;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rdv;
   logic pready, pslverr, erv, hso, lso, fa, ca, f32, clr;
   logic en = 1'b0, lock = 1'b0, gh = 1'b0, gl = 1'b0, chp = 1'b0;
   logic act = 1'b0, oth = 1'b0, pol = 1'b0, cl = 1'b0;
   logic [1:0] flv = 2'h2, clv = 2'h1;
   logic [2:0] g = 3'h0, oh;
   logic [4:0] src = 5'h0, s, cmp;
   logic [7:0] fp;
   logic [15:0] lc [7] = '{16'h8800, 16'h4800, 16'h2800, 16'h1800, 16'h8000, 16'h2800, 16'h8400};
   logic [1:0] gv [7] = '{2'h2, 2'h0, 2'h1, 2'h0, 2'h2, 2'h0, 2'h2};
   int ex [7] = '{D + 1, D + 1, D + 1, D + 1, 0, 0, D + 1};
   int fail_count = 0, n_checks = 0, cyc = 0, n;
   always #12.5 pclk = ~pclk;
   pfb_core i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'h3), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .fault_pins(fp), .fault32_pin(f32), .cmp_outs(cmp),
      .climit_source_sel_in(5'h0), .climit_raw_in(clr), .fault_output_levels(flv),
      .climit_output_levels(clv), .pwm_module_enable(en), .write_lock_config(lock),
      .gen_high_in(gh), .gen_low_in(gl), .generator1_high_output(g[0]),
      .generator2_high_output(g[1]), .generator3_high_output(g[2]), .chop_clock(chp),
      .high_side_output(hso), .low_side_output(lso), .fault_active(fa), .climit_active(ca));
   pfb_far_model i_far (.pclk(pclk), .src(src), .act(act), .oth(oth), .pol(pol), .cl(cl),
      .fault_pins(fp), .fault32_pin(f32), .cmp_outs(cmp), .climit_raw_in(clr));
   ////////////////////////////////////////////////////////////
   task automatic tick(input int k);
      repeat (k) @(posedge pclk);
   endtask : tick
   task automatic acc(input logic w, input logic [31:0] a, input logic [15:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {16'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rdv = prdata;
      erv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : acc
   task automatic wr(input logic [31:0] a, input logic [15:0] d, input logic ee);
      acc(1'b1, a, d);
      `CK("write error", ee, erv)
   endtask : wr
   task automatic rd(input logic [31:0] a, input logic [15:0] e, input logic ee);
      acc(1'b0, a, 16'h0);
      `CK("read error", ee, erv)
      `CK("read data", {16'h0, e}, rdv)
   endtask : rd
   task automatic fchk(input logic e);
      tick(5);
      `CK("fault active", e, fa)
   endtask : fchk
   task automatic results();
      if (fail_count == 0 && n_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : results
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         results();
      end
   end
   ////////////////////////////////////////////////////////////
   initial begin
      tick(4);
      presetn <= 1'b1;
      tick(1);
      rd(32'h0, 16'h00f8, 1'b0);
      wr(32'h4, 16'hffff, 1'b0);
      rd(32'h4, 16'hfc3f, 1'b0);
      wr(32'h8, 16'hffff, 1'b0);
      rd(32'h8, 16'h0fff, 1'b0);
      wr(32'hc, 16'hffff, 1'b0);
      rd(32'hc, 16'h0f3f, 1'b0);
      rd(32'h1c, 16'h0, 1'b1);
      wr(32'h1c, 16'h1, 1'b1);
      wr(32'h4, 16'h0, 1'b0);
      wr(32'hc, 16'h0, 1'b0);
      lock <= 1'b1;
      wr(32'h0, 16'h0001, 1'b1);
      rd(32'h0, 16'h00f8, 1'b0);
      wr(32'h14, 16'h00aa, 1'b0);
      wr(32'h14, 16'h0055, 1'b0);
      wr(32'h0, 16'h0001, 1'b0);
      wr(32'h0, 16'h0001, 1'b1);
      lock <= 1'b0;
      for (int p = 0; p < 2; p++) begin
         for (int i = 0; i < 14; i++) begin
            s = (i < 13) ? 5'(i) : 5'h1f;
            src <= s;
            pol <= p[0];
            wr(32'h0, {8'h0, s, p[0], 2'h1}, 1'b0);
            oth <= 1'b1;
            fchk(1'b0);
            oth <= 1'b0;
            act <= 1'b1;
            fchk(1'b1);
            `CK("fault outputs", 2'h2, {hso, lso})
            act <= 1'b0;
            fchk(1'b0);
         end
      end
      src <= 5'h0;
      pol <= 1'b0;
      wr(32'h0, 16'h0000, 1'b0);
      en <= 1'b1;
      act <= 1'b1;
      fchk(1'b1);
      rd(32'h18, 16'h0001, 1'b0);
      act <= 1'b0;
      fchk(1'b1);
      en <= 1'b0;
      fchk(1'b0);
      for (int m = 2; m < 4; m++) begin
         wr(32'h0, {14'h0, 2'(m)}, 1'b0);
         act <= 1'b1;
         fchk(1'b0);
         act <= 1'b0;
      end
      wr(32'h8, 16'(D), 1'b0);
      wr(32'h0, 16'h0001, 1'b0);
      act <= 1'b1;
      fchk(1'b1);
      for (int i = 0; i < 7; i++) begin
         if (i == 6) begin
            wr(32'h0, 16'h0103, 1'b0);
            cl <= 1'b1;
            tick(5);
            `CK("limit outputs", 2'h1, {hso, lso})
         end
         wr(32'h4, lc[i], 1'b0);
         {gh, gl} <= gv[i];
         n = 0;
         repeat (20) begin
            @(posedge pclk);
            if (((i == 6) ? ca : fa) !== 1'b1) n++;
         end
         `CK("blank cycles", ex[i], n)
      end
      cl <= 1'b0;
      wr(32'h0, 16'h0001, 1'b0);
      for (int b = 0; b < 4; b++) begin
         wr(32'h4, 16'(1 << b), 1'b0);
         gh <= (b == 3);
         gl <= (b == 1);
         fchk(1'b0);
         if (b > 1) gh <= ~gh;
         else gl <= ~gl;
         fchk(1'b1);
      end
      for (int k = 0; k < 4; k++) begin
         oh = (k == 0) ? 3'h0 : 3'(1 << (k - 1));
         wr(32'hc, 16'(k << 8), 1'b0);
         wr(32'h4, 16'h0020, 1'b0);
         g <= oh;
         fchk(k == 0);
         wr(32'h4, 16'h0010, 1'b0);
         g <= ~oh;
         fchk(k == 0);
      end
      wr(32'h4, 16'h0, 1'b0);
      wr(32'h0, 16'h0003, 1'b0);
      act <= 1'b0;
      gh <= 1'b1;
      gl <= 1'b1;
      for (int k = 0; k < 4; k++) begin
         oh = (k == 0) ? 3'h0 : 3'(1 << (k - 1));
         wr(32'hc, 16'(k << 2) | 16'h3, 1'b0);
         for (int l = 0; l < 2; l++) begin
            chp <= (k == 0) ? l[0] : ~l[0];
            g <= l[0] ? oh : ~oh;
            tick(5);
            `CK("chopped outputs", {l[0], l[0]}, {hso, lso})
         end
      end
      wr(32'hc, 16'h0006, 1'b0);
      g <= 3'h0;
      tick(5);
      `CK("high chop only", 2'h1, {hso, lso})
      results();
   end
endmodule : pwm_fault_blanking_chop_tb_top
`default_nettype wire
